// [src/ubd_baud_divisor.v]
/*
  baud-rate divisor register pair of a serial port with its prescaler
  and bit-rate generator, reached over avalon-mm with waitrequest.
  assumes one clock (mclk_i, 250 MHz) and an asynchronous active-low
  reset; frame-control storage is the target of writes that land on
  the shared location with the select bit set, reads back at the
  frame view offset and gates double speed through its sync bit.
*/
`timescale 1ns/100ps
`include "ubd_regs.vh"

// Contract
// - the divisor high byte shares its location with the frame-control register and the written select bit picks the target.
// - reading the divisor high byte returns zero in the select bit.
// - the 12-bit divisor takes its upper four bits from the high byte and its lower eight from the low byte.
// - writing the low byte reloads the prescaler at once with the new divisor.
// - with double speed set in asynchronous mode the oversampling factor is eight instead of sixteen.
module ubd_baud_divisor (
  // clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // avalon-mm slave
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  // baud generator
  output reg [11:0] baud_divisor_o,
  output reg double_speed_o,
  output reg [6:0] frame_control_o,
  output reg sample_tick_o,
  output reg bit_tick_o
);

  // ****************************************
  // register storage
  // ****************************************
  reg [7:0] div_low;
  reg [3:0] div_high;
  reg [6:0] frame_ctrl;
  reg double_speed_bit;
  reg [11:0] prescale_cnt;
  reg [3:0] ovs_cnt;

  wire req;
  wire commit;
  wire lane0;
  wire wr_low;
  wire wr_shared;
  wire wr_mode;
  wire sel_frame;
  wire dspeed_eff;
  wire [3:0] ovs_last;
  wire [11:0] divisor;
  wire [11:0] new_divisor;
  reg [31:0] next_readdata;

  assign req = avs_read_i | avs_write_i;
  // the transfer completes on the edge where waitrequest is seen low
  assign commit = req & ~avs_waitrequest_o;
  assign lane0 = avs_byteenable_i[0];
  assign wr_low = commit & avs_write_i & lane0 & (avs_address_i == `UBD_OFS_DIV_LOW);
  assign wr_shared = commit & avs_write_i & lane0 & (avs_address_i == `UBD_OFS_DIV_HIGH);
  assign wr_mode = commit & avs_write_i & lane0 & (avs_address_i == `UBD_OFS_MODE);
  assign sel_frame = avs_writedata_i[`UBD_SEL_BIT];
  assign divisor = {div_high, div_low};
  assign new_divisor = {div_high, avs_writedata_i[7:0]};
  // double speed has no meaning in synchronous mode
  assign dspeed_eff = double_speed_bit & ~frame_ctrl[`UBD_FRM_SYNC_BIT];
  assign ovs_last = dspeed_eff ? `UBD_OVS_DOUBLE_LAST : `UBD_OVS_NORMAL_LAST;

  // ****************************************
  // bus handshake: one wait state per transfer
  // ****************************************
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (req && avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  // ****************************************
  // read mux, registered ahead of the wait state's release
  // ****************************************
  always @* begin
    next_readdata = 32'h00000000;
    case (avs_address_i)
      `UBD_OFS_DIV_LOW: begin
        next_readdata[7:0] = div_low;
      end
      `UBD_OFS_DIV_HIGH: begin
        // select and reserved bits read as zero
        next_readdata[`UBD_HIGH_MSB:0] = div_high;
      end
      `UBD_OFS_MODE: begin
        next_readdata[`UBD_MODE_DSPEED_BIT] = double_speed_bit;
      end
      `UBD_OFS_FRAME_VIEW: begin
        next_readdata[`UBD_SEL_BIT] = 1'b1;
        next_readdata[6:0] = frame_ctrl;
      end
      default: begin
        next_readdata = 32'h00000000;
      end
    endcase
  end

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= next_readdata;
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_low <= `UBD_RST_DIV_LOW;
      div_high <= `UBD_RST_DIV_HIGH;
      frame_ctrl <= `UBD_RST_FRAME;
      double_speed_bit <= `UBD_RST_MODE;
    end else begin
      if (wr_low) begin
        div_low <= avs_writedata_i[7:0];
      end
      // shared location: select bit steers the write
      if (wr_shared && sel_frame) begin
        frame_ctrl <= avs_writedata_i[6:0];
      end
      if (wr_shared && !sel_frame) begin
        // reserved bits 6:4 are not stored
        div_high <= avs_writedata_i[`UBD_HIGH_MSB:0];
      end
      if (wr_mode) begin
        double_speed_bit <= avs_writedata_i[`UBD_MODE_DSPEED_BIT];
      end
    end
  end

  // ****************************************
  // prescaler and oversampling divider
  // ****************************************
  // a new divisor in the middle of a frame distorts that frame;
  // nothing here guards against it
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prescale_cnt <= 12'h000;
      ovs_cnt <= 4'h0;
      sample_tick_o <= 1'b0;
      bit_tick_o <= 1'b0;
    end else if (wr_low) begin
      // reload now, not at the end of the running period
      prescale_cnt <= new_divisor;
      ovs_cnt <= 4'h0;
      sample_tick_o <= 1'b0;
      bit_tick_o <= 1'b0;
    end else if (prescale_cnt == 12'h000) begin
      // one sample tick every divisor+1 clocks
      prescale_cnt <= divisor;
      sample_tick_o <= 1'b1;
      if (ovs_cnt >= ovs_last) begin
        ovs_cnt <= 4'h0;
        bit_tick_o <= 1'b1;
      end else begin
        ovs_cnt <= ovs_cnt + 4'h1;
        bit_tick_o <= 1'b0;
      end
    end else begin
      prescale_cnt <= prescale_cnt - 12'h001;
      sample_tick_o <= 1'b0;
      bit_tick_o <= 1'b0;
    end
  end

  // ****************************************
  // registered status outputs
  // ****************************************
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      baud_divisor_o <= 12'h000;
      double_speed_o <= 1'b0;
      frame_control_o <= `UBD_RST_FRAME;
    end else begin
      baud_divisor_o <= divisor;
      double_speed_o <= dspeed_eff;
      frame_control_o <= frame_ctrl;
    end
  end

endmodule

// [pkg/ubd_regs.vh]
/*
  offsets, field positions, reset values and counts of the uart baud
  divisor register block; assumes a 32-bit avalon-mm slave with byte
  addresses, one aligned word per register, data in the low byte
*/
`ifndef UBD_REGS_VH
`define UBD_REGS_VH

// ****************************************
// register byte offsets
// ****************************************
`define UBD_OFS_DIV_LOW 4'h0
`define UBD_OFS_DIV_HIGH 4'h4
`define UBD_OFS_MODE 4'h8
`define UBD_OFS_FRAME_VIEW 4'hC

// ****************************************
// field positions
// ****************************************
`define UBD_SEL_BIT 7
`define UBD_HIGH_MSB 3
`define UBD_FRM_SYNC_BIT 6
`define UBD_MODE_DSPEED_BIT 0

// ****************************************
// reset values
// ****************************************
`define UBD_RST_DIV_LOW 8'h00
`define UBD_RST_DIV_HIGH 4'h0
`define UBD_RST_FRAME 7'h06
`define UBD_RST_MODE 1'b0

// ****************************************
// oversampling counts (terminal values)
// ****************************************
`define UBD_OVS_NORMAL_LAST 4'hF
`define UBD_OVS_DOUBLE_LAST 4'h7

`endif

// [bench/ubd_baud_divisor_assertions.sv]
/* port assertions for the baud divisor block; assumes one clock, async low reset */
`timescale 1ns/100ps
module ubd_baud_divisor_assertions (
  input wire mclk_i, input wire rst_n_i, input wire avs_read_i, input wire avs_write_i,
  input wire [3:0] avs_address_i, input wire [3:0] avs_byteenable_i,
  input wire [31:0] avs_writedata_i, input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o, input wire [11:0] baud_divisor_o, input wire double_speed_o,
  input wire [6:0] frame_control_o, input wire sample_tick_o, input wire bit_tick_o
);
  // ****************************************
  // last committed write values
  // ****************************************
  wire wt = avs_waitrequest_o;
  wire cmt = avs_write_i && !wt && avs_byteenable_i[0];
  wire hi_wr = cmt && avs_address_i == 4'h4;
  wire lo_wr = cmt && avs_address_i == 4'h0;
  reg [7:0] exp_lo;
  reg [6:0] exp_hi;
  always @(posedge mclk_i) begin
    if (lo_wr) exp_lo <= avs_writedata_i[7:0];
    if (hi_wr) exp_hi <= avs_writedata_i[6:0];
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_wait_single: assert property ((avs_read_i || avs_write_i) && wt |=> !wt)
    else $error("more than one wait state");
  a_high_readback: assert property (avs_read_i && !wt && avs_address_i == 4'h4 |->
    avs_readdata_o[31:4] == 28'h0) else $error("high byte read shows select or reserved bits");
  a_low_write: assert property (lo_wr |-> ##[1:2] baud_divisor_o[7:0] == exp_lo)
    else $error("low divisor byte not taken");
  a_high_write: assert property (hi_wr && !avs_writedata_i[7] |->
    ##[1:2] baud_divisor_o[11:8] == exp_hi[3:0]) else $error("high divisor bits not taken");
  a_frame_write: assert property (hi_wr && avs_writedata_i[7] |->
    ##[1:2] frame_control_o == exp_hi) else $error("frame control not taken");
  a_sel_keeps_div: assert property (hi_wr && avs_writedata_i[7] |=>
    $stable(baud_divisor_o[11:8]) [*2]) else $error("frame write changed divisor");
  a_reload_quiet: assert property (lo_wr |=> !sample_tick_o && !bit_tick_o)
    else $error("tick right after reload");
  a_bit_on_sample: assert property (bit_tick_o |-> sample_tick_o)
    else $error("bit tick without sample tick");
  a_bit_pulse: assert property (bit_tick_o |=> !bit_tick_o)
    else $error("bit tick longer than one cycle");
  a_dspeed_async: assert property (double_speed_o |-> !frame_control_o[6])
    else $error("double speed in synchronous mode");
endmodule
bind ubd_baud_divisor ubd_baud_divisor_assertions ubd_baud_divisor_assertions_inst (.mclk_i,
  .rst_n_i, .avs_read_i, .avs_write_i, .avs_address_i, .avs_byteenable_i, .avs_writedata_i,
  .avs_readdata_o, .avs_waitrequest_o, .baud_divisor_o, .double_speed_o, .frame_control_o,
  .sample_tick_o, .bit_tick_o);

// [bench/uart_baud_divisor_registers_tb_top.sv]
/* self-checking bench for the baud divisor block; drives avalon-mm itself */
`timescale 1ns/100ps
module uart_baud_divisor_registers_tb_top;
  reg mclk_i = 0, rst_n_i = 0, rd = 0, wr = 0;
  reg [3:0] adr = 4'h0, be = 4'h0;
  reg [31:0] wd = 32'h0, rdat, s = 32'hEBC0A693;
  reg [7:0] lo, hi;
  wire [31:0] rdo;
  wire [11:0] dvo;
  wire [6:0] fco;
  wire wt, dso, sto, bto;
  integer n_errors = 0, tests_run = 0, c, i;
  initial forever #2 mclk_i = ~mclk_i;
  ubd_baud_divisor ubd_baud_divisor_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdo), .avs_waitrequest_o(wt),
    .baud_divisor_o(dvo), .double_speed_o(dso), .frame_control_o(fco),
    .sample_tick_o(sto), .bit_tick_o(bto));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // request held until waitrequest is sampled low; read data taken at that edge
  task bus(input w, input [3:0] a, input [31:0] d, input [3:0] b);
    @(posedge mclk_i);
    adr <= a; wd <= d; be <= b; wr <= w; rd <= !w;
    do @(posedge mclk_i); while (wt !== 1'b0);
    rdat = rdo;
    wr <= 0;
    rd <= 0;
  endtask
  task cnt(input sel, output integer k);
    k = 0;
    do begin @(posedge mclk_i); #1 k++; end while ((sel ? bto : sto) !== 1'b1 && k < 9000);
  endtask
  task final_report;
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    final_report;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1;
    bus(0, 4'h0, 0, 4'hF); chk(rdat, 0);
    bus(0, 4'h4, 0, 4'hF); chk(rdat, 0);
    bus(0, 4'hC, 0, 4'hF); chk(rdat, 32'h86);
    bus(0, 4'h1, 0, 4'hF); chk(rdat, 0);
    for (i = 0; i < 12; i++) begin
      lo = (i == 0) ? 8'hFF : 8'(rnd());
      hi = (i == 0) ? 8'h0F : 8'(rnd()) & 8'h0F; // select and reserved bits kept zero
      bus(1, 4'h4, hi, 4'h1);
      bus(1, 4'h0, lo, 4'h1);
      bus(0, 4'h0, 0, 4'h0); chk(rdat, lo);
      bus(0, 4'h4, 0, 4'h0); chk(rdat, hi);
      chk(dvo, {hi[3:0], lo});
    end
    bus(1, 4'h0, 8'h33, 4'h0); // byteenable clear: ignored
    bus(1, 4'h4, 8'hC5, 4'h1);
    bus(0, 4'hC, 0, 4'h0); chk(rdat, 32'hC5);
    chk(fco, 7'h45); chk(dvo, {hi[3:0], lo});
    bus(1, 4'h8, 1, 4'h1);
    bus(0, 4'h8, 0, 4'h0); chk(rdat, 32'h1);
    chk(dso, 0);
    bus(1, 4'h4, 8'h86, 4'h1);
    bus(1, 4'h4, 0, 4'h1);
    // divisor rewritten a few clocks into a running 0x40 period, so the reload lands inside a bit period
    for (i = 0; i < 4; i++) begin
      lo = (i == 0) ? 8'h00 : 8'(rnd() % 10 + 1);
      bus(1, 4'h8, i[1], 4'h1);
      bus(1, 4'h0, 8'h40, 4'h1);
      repeat (rnd() % 20) @(posedge mclk_i);
      bus(1, 4'h0, lo, 4'h1);
      cnt(0, c); chk(c, lo + 1);
      cnt(1, c);
      cnt(1, c); chk(c, (lo + 1) * (i[1] ? 8 : 16));
      chk(dso, i[1]);
    end
    final_report;
  end
endmodule
